// file: pscl_checker.sv
// Port assertions for the strap configuration loader
module pscl_checker #(
  parameter int SoftRstCycles = pscl_pkg::SRST_CYCLES
) (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        porReset,
  input wire logic        hardware_reset_pin_n,
  input wire logic [4:0]  station_address_straps,
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [15:0] regRdata,
  input wire logic        mgmtFrameValid,
  input wire logic [4:0]  mgmtFrameAddr,
  input wire logic        mgmtAddrMatch,
  input wire logic [4:0]  scramblerSeed,
  input wire logic        rxActive,
  input wire logic        txActive,
  input wire logic        carrierSense,
  input wire logic [4:0]  indicatorRaw,
  input wire logic [4:0]  indicatorOut,
  input wire logic        coreReset,
  input wire logic        powerDown,
  input wire logic [15:0] ctrlValue
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic hw;
  // Combined hardware reset
  assign hw = porReset | ~hardware_reset_pin_n;
  sequence capSeq;
    $past(hw) && !hw;
  endsequence
  sequence srstReq;
    regWrite && regAddr == pscl_pkg::REG_CTRL_OFS && regWdata[15] && !coreReset && !hw;
  endsequence
  // Soft reset stretch below assumes an 8-cycle setting
  a_seed_capture: assert property (capSeq |=> scramblerSeed == $past(station_address_straps))
    else $error("seed not captured at reset release");
  a_seed_hold: assert property (!hw && !$past(hw) |=> $stable(scramblerSeed))
    else $error("seed changed after capture");
  a_match_hit: assert property (mgmtFrameValid && mgmtFrameAddr == scramblerSeed && !coreReset |=> mgmtAddrMatch)
    else $error("matching frame not answered");
  a_match_miss: assert property (!(mgmtFrameValid && mgmtFrameAddr == scramblerSeed) |=> !mgmtAddrMatch)
    else $error("match without address equality");
  a_crs_rx: assert property (rxActive && !powerDown && !coreReset |=> carrierSense)
    else $error("carrier sense missing on receive");
  a_crs_idle: assert property (!rxActive && !txActive |=> !carrierSense)
    else $error("carrier sense while idle");
  a_ind_pol: assert property (1'b1 |=> indicatorOut == ($past(indicatorRaw) ^ $past(scramblerSeed)))
    else $error("indicator polarity wrong");
  a_srst_len: assert property (srstReq |=> coreReset [*8] ##[1:2] !coreReset)
    else $error("soft reset length wrong");
  a_hw_core: assert property (hw |=> coreReset && ctrlValue == pscl_pkg::CTRL_RESET)
    else $error("hardware reset not applied");
  a_rdata_idle: assert property (!regRead |=> regRdata == 16'h0000)
    else $error("read data outside read slot");
endmodule // pscl_checker

bind pscl_loader pscl_checker #(.SoftRstCycles(SoftRstCycles)) u_chk (.mclk, .arst_n, .porReset,
  .hardware_reset_pin_n, .station_address_straps, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
  .mgmtFrameValid, .mgmtFrameAddr, .mgmtAddrMatch, .scramblerSeed, .rxActive, .txActive, .carrierSense,
  .indicatorRaw, .indicatorOut, .coreReset, .powerDown, .ctrlValue);

// file: pscl_loader.sv
// Strap capture, mode decode and soft reset sequencing of the transceiver
//
// Overview of operation
// - Station address straps are latched when hardware reset ends, then held.
// - Management frames answered only when their address field equals latched address.
// - Latched station address seeds the transmit scrambler.
// - Mode straps load control bits at hardware reset release; logic follows those bits.
// - Soft reset keeps current register values and resamples mode straps only when stuck in code 110.
// - Codes 000/001 give 10 Mb/s half/full duplex, negotiation off.
// - Codes 010/011 give 100 Mb/s half/full duplex, negotiation off.
// - Code 100 enables negotiation, control 1100, advertises only 100 half duplex.
// - Code 101 selects repeater, negotiation on, control 1100, advertisement 0100.
// - Code 111 enables negotiation, control X10X, advertises all abilities.
// - Code 110 powers down; leaving needs new strap code plus soft reset.
// - Carrier sense on transmit and receive for 010/100, receive only for 011/101.
// - Each latched address bit sets one indicator polarity; one means active-low.
// - Writing control bit 15 starts self-clearing soft reset held 256 us.
// - Power-on reset OR'ed with reset pin forms the hardware reset.
//
// Strap inputs are taken as synchronous to mclk; the board keeps them steady.
// The release edge of the merged reset comes from its registered copy, so a
// reset shorter than one clock may be missed entirely.
// A hardware reset always wins over a soft reset that is still counting.
// Code 110 keeps the power-down bit set until straps change and a soft reset ends.
// Indicator outputs follow their requests one clock later, never combinationally.
// Widths are fixed; only the soft reset stretch may be shortened for tests.
// Control and advertisement registers fall back to their reset values while the hardware reset holds.
module pscl_loader #(
  parameter int SoftRstCycles = pscl_pkg::SRST_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        porReset,
  input  wire logic        hardware_reset_pin_n,
  input  wire logic [4:0]  station_address_straps,
  input  wire logic [2:0]  modeStraps,
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [15:0] regRdata,
  input  wire logic        mgmtFrameValid,
  input  wire logic [4:0]  mgmtFrameAddr,
  output logic             mgmtAddrMatch,
  output logic      [4:0]  scramblerSeed,
  input  wire logic        txActive,
  input  wire logic        rxActive,
  output logic             carrierSense,
  input  wire logic [4:0]  indicatorRaw,
  output logic      [4:0]  indicatorOut,
  output logic             coreReset,
  output logic             powerDown,
  output logic             repeaterMode,
  output logic      [15:0] ctrlValue,
  output logic      [15:0] advValue
);

  // Table of strap defaults for one mode code
  function automatic pscl_pkg::pscl_mode_cfg_s decodeMode(input logic [2:0] code);
    pscl_pkg::pscl_mode_cfg_s c;
    c = '0;
    case (code)
      // 10 Mb/s half duplex, carrier also on transmit
      pscl_pkg::MODE_10HD: begin
        c.ctrlBits = 4'h0;
        c.crsOnTx  = 1'b1;
      end

      // 10 Mb/s full duplex, carrier on receive only
      pscl_pkg::MODE_10FD: begin
        c.ctrlBits = 4'h1;
      end

      // 100 Mb/s half duplex
      pscl_pkg::MODE_100HD: begin
        c.ctrlBits = 4'h8;
        c.crsOnTx  = 1'b1;
      end

      // 100 Mb/s full duplex
      pscl_pkg::MODE_100FD: begin
        c.ctrlBits = 4'h9;
        c.crsOnTx  = 1'b0;
      end

      // Negotiation with only 100 half duplex offered
      pscl_pkg::MODE_AN100HD: begin
        c.ctrlBits = 4'hc;
        c.advValid = 1'b1;
        c.advBits  = 4'h4;
        c.crsOnTx  = 1'b1;
      end

      // Repeater with negotiation
      pscl_pkg::MODE_REPEATER: begin
        c.ctrlBits = 4'hc;
        c.advValid = 1'b1;
        c.advBits  = 4'h4;
        c.repeater = 1'b1;
        c.crsOnTx  = 1'b0;
      end

      // Powered down, no speed or ability defaults
      pscl_pkg::MODE_PWRDOWN: begin
        c.powerDown = 1'b1;
      end

      // All abilities offered
      default: begin
        // Don't-care speed and duplex taken as ones
        c.ctrlBits = 4'hd;
        c.advValid = 1'b1;
        c.advBits  = 4'hf;
        c.crsOnTx  = 1'b1;
      end
    endcase
    return c;
  endfunction

  // Combined hardware reset, active high
  // Both sources merge before the release edge is looked for
  logic hwReset;
  assign hwReset = porReset | ~hardware_reset_pin_n;

  // Loader state and previous level of the merged hardware reset
  pscl_pkg::pscl_state_e          state_q, state_d;
  logic                           hwRst_q, hwRst_d;

  // Latched straps and their decoded side effects
  logic [4:0]                     addr_q, addr_d;
  logic [2:0]                     mode_q, mode_d;
  logic                           crsOnTx_q, crsOnTx_d;
  logic                           repeater_q, repeater_d;

  // Control and advertisement registers
  logic [15:0]                    ctrl_q, ctrl_d;
  logic [15:0]                    adv_q, adv_d;

  // Soft reset stretch counter
  logic [pscl_pkg::SRST_CNT_W-1:0] cnt_q, cnt_d;

  // Registered port outputs
  logic [15:0]                    rdata_q, rdata_d;
  logic                           match_q, match_d;
  logic                           crs_q, crs_d;
  logic [4:0]                     ind_q, ind_d;

  // Decode helpers
  logic                           capture;
  logic                           wrCtrl;
  logic                           wrAdv;
  pscl_pkg::pscl_mode_cfg_s       strapCfg;

  // Last count of the soft reset stretch
  localparam logic [pscl_pkg::SRST_CNT_W-1:0] SrstLast =
    pscl_pkg::SRST_CNT_W'(SoftRstCycles - 1);

  // Release edge of the hardware reset and register write decode
  assign capture  = hwRst_q & ~hwReset;
  assign strapCfg = decodeMode(modeStraps);
  assign wrCtrl   = regWrite && (regAddr == pscl_pkg::REG_CTRL_OFS);
  assign wrAdv    = regWrite && (regAddr == pscl_pkg::REG_ADV_OFS);

  // Strap latch, configuration registers and soft reset sequencing
  always_comb begin
    state_d    = state_q;
    hwRst_d    = hwReset;
    addr_d     = addr_q;
    mode_d     = mode_q;
    crsOnTx_d  = crsOnTx_q;
    repeater_d = repeater_q;
    ctrl_d     = ctrl_q;
    adv_d      = adv_q;
    cnt_d      = cnt_q;
    case (state_q)
      pscl_pkg::ST_HWRST: begin
        // Registers sit at reset values until the straps are taken
        ctrl_d = pscl_pkg::CTRL_RESET;
        adv_d  = pscl_pkg::ADV_RESET;
        // Straps taken only in the release cycle
        if (capture) begin
          addr_d     = station_address_straps;
          mode_d     = modeStraps;
          crsOnTx_d  = strapCfg.crsOnTx;
          repeater_d = strapCfg.repeater;
          ctrl_d[pscl_pkg::CTRL_SPD_BIT]  = strapCfg.ctrlBits[3];
          ctrl_d[pscl_pkg::CTRL_ANEN_BIT] = strapCfg.ctrlBits[2];
          ctrl_d[pscl_pkg::CTRL_ISO_BIT]  = strapCfg.ctrlBits[1];
          ctrl_d[pscl_pkg::CTRL_DPX_BIT]  = strapCfg.ctrlBits[0];
          ctrl_d[pscl_pkg::CTRL_PDN_BIT]  = strapCfg.powerDown;
          if (strapCfg.advValid) begin
            adv_d[pscl_pkg::ADV_ABIL_LSB +: 4] = strapCfg.advBits;
          end
          state_d = pscl_pkg::ST_RUN;
        end
      end

      pscl_pkg::ST_RUN: begin
        // Software writes; bit 15 is never stored, it reads back as busy
        if (wrCtrl) begin
          ctrl_d = regWdata;
          ctrl_d[pscl_pkg::CTRL_SRST_BIT] = 1'b0;
          // Powered-down strap stays stuck unless the straps change and a soft reset follows
          if (mode_q == pscl_pkg::MODE_PWRDOWN) begin
            ctrl_d[pscl_pkg::CTRL_PDN_BIT] = 1'b1;
          end
        end
        if (wrAdv) begin
          adv_d = regWdata;
        end
        // A one in bit 15 starts the stretched soft reset
        if (wrCtrl && regWdata[pscl_pkg::CTRL_SRST_BIT]) begin
          cnt_d   = '0;
          state_d = pscl_pkg::ST_SRST;
        end
      end

      pscl_pkg::ST_SRST: begin
        // Registers keep their values; straps are looked at only at the end, in the power-down case
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == SrstLast) begin
          cnt_d   = '0;
          state_d = pscl_pkg::ST_RUN;
          // Only the stuck power-down case looks at the mode straps again
          // The station address is never taken again here
          if (mode_q == pscl_pkg::MODE_PWRDOWN &&
              modeStraps != pscl_pkg::MODE_PWRDOWN) begin
            mode_d     = modeStraps;
            crsOnTx_d  = strapCfg.crsOnTx;
            repeater_d = strapCfg.repeater;
            ctrl_d[pscl_pkg::CTRL_SPD_BIT]  = strapCfg.ctrlBits[3];
            ctrl_d[pscl_pkg::CTRL_ANEN_BIT] = strapCfg.ctrlBits[2];
            ctrl_d[pscl_pkg::CTRL_ISO_BIT]  = strapCfg.ctrlBits[1];
            ctrl_d[pscl_pkg::CTRL_DPX_BIT]  = strapCfg.ctrlBits[0];
            ctrl_d[pscl_pkg::CTRL_PDN_BIT]  = 1'b0;
            if (strapCfg.advValid) begin
              adv_d[pscl_pkg::ADV_ABIL_LSB +: 4] = strapCfg.advBits;
            end
          end
        end
      end

      default: begin
        state_d = pscl_pkg::ST_HWRST;
      end
    endcase
    // Hardware reset overrides state, count, control and advertisement, including a soft reset
    if (hwReset) begin
      state_d = pscl_pkg::ST_HWRST;
      cnt_d   = '0;
      ctrl_d  = pscl_pkg::CTRL_RESET;
      adv_d   = pscl_pkg::ADV_RESET;
    end
  end

  // Registers of the loader; next values come from the process above
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= pscl_pkg::ST_HWRST;
      hwRst_q    <= 1'b1;
      addr_q     <= pscl_pkg::ADDR_RESET;
      mode_q     <= pscl_pkg::MODE_RESET;
      crsOnTx_q  <= 1'b0;
      repeater_q <= 1'b0;
      ctrl_q     <= pscl_pkg::CTRL_RESET;
      adv_q      <= pscl_pkg::ADV_RESET;
      cnt_q      <= '0;
    end else begin
      state_q    <= state_d;
      hwRst_q    <= hwRst_d;
      addr_q     <= addr_d;
      mode_q     <= mode_d;
      crsOnTx_q  <= crsOnTx_d;
      repeater_q <= repeater_d;
      ctrl_q     <= ctrl_d;
      adv_q      <= adv_d;
      cnt_q      <= cnt_d;
    end
  end

  // Read data, address match, carrier sense and indicator polarity
  always_comb begin
    rdata_d = '0;
    // Read data stand for one cycle after the strobe
    if (regRead) begin
      case (regAddr)
        pscl_pkg::REG_CTRL_OFS: begin
          rdata_d = ctrl_q;
          rdata_d[pscl_pkg::CTRL_SRST_BIT] = (state_q == pscl_pkg::ST_SRST);
        end
        pscl_pkg::REG_ADV_OFS: begin
          rdata_d = adv_q;
        end
        pscl_pkg::REG_STAT_OFS: begin
          rdata_d = {5'h00, repeater_q, crsOnTx_q,
                     (state_q == pscl_pkg::ST_SRST), mode_q, addr_q};
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
    // No match while the hardware reset holds
    match_d = mgmtFrameValid && (mgmtFrameAddr == addr_q) &&
              (state_q != pscl_pkg::ST_HWRST);
    // Carrier from receive, and from transmit where the mode asks
    crs_d   = rxActive | (crsOnTx_q & txActive);
  end

  // Per-indicator polarity from the matching latched address bit
  for (genvar i = 0; i < 5; i++) begin : g_ind
    assign ind_d[i] = indicatorRaw[i] ^ addr_q[i];
  end

  // Registers of the port outputs
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= pscl_pkg::RDATA_RESET;
      match_q <= 1'b0;
      crs_q   <= 1'b0;
      ind_q   <= 5'h00;
    end else begin
      rdata_q <= rdata_d;
      match_q <= match_d;
      crs_q   <= crs_d;
      ind_q   <= ind_d;
    end
  end

  // Outputs toward the core logic
  // Seed follows the latched address directly; indicators pass through a register
  assign regRdata      = rdata_q;
  assign mgmtAddrMatch = match_q;
  assign scramblerSeed = addr_q;
  assign carrierSense  = crs_q;
  assign indicatorOut  = ind_q;
  assign coreReset     = (state_q != pscl_pkg::ST_RUN);
  assign powerDown     = ctrl_q[pscl_pkg::CTRL_PDN_BIT];
  assign repeaterMode  = repeater_q;
  assign ctrlValue     = ctrl_q;
  assign advValue      = adv_q;

endmodule // pscl_loader

// file: pscl_pkg.sv
// Constants and types for the strap configuration loader
package pscl_pkg;

  // Register word offsets on the plain register port
  localparam logic [7:0]  REG_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  REG_ADV_OFS    = 8'h04;
  localparam logic [7:0]  REG_STAT_OFS   = 8'h08;

  // Basic-control field positions
  localparam int          CTRL_SRST_BIT  = 15;
  localparam int          CTRL_SPD_BIT   = 13;
  localparam int          CTRL_ANEN_BIT  = 12;
  localparam int          CTRL_PDN_BIT   = 11;
  localparam int          CTRL_ISO_BIT   = 10;
  localparam int          CTRL_DPX_BIT   = 8;
  // Advertisement field (four ability bits) lowest position
  localparam int          ADV_ABIL_LSB   = 5;

  // Values after reset
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] ADV_RESET      = 16'h0001;
  localparam logic [15:0] RDATA_RESET    = 16'h0000;
  localparam logic [4:0]  ADDR_RESET     = 5'h00;
  localparam logic [2:0]  MODE_RESET     = 3'h0;

  // Soft reset stretch time and its cycle count at the core clock
  localparam int          CLK_MHZ        = 100;
  localparam int          SRST_US        = 256;
  localparam int          SRST_CYCLES    = SRST_US * CLK_MHZ;
  localparam int          SRST_CNT_W     = 15;

  // Mode strap codes
  localparam logic [2:0]  MODE_10HD      = 3'h0;
  localparam logic [2:0]  MODE_10FD      = 3'h1;
  localparam logic [2:0]  MODE_100HD     = 3'h2;
  localparam logic [2:0]  MODE_100FD     = 3'h3;
  localparam logic [2:0]  MODE_AN100HD   = 3'h4;
  localparam logic [2:0]  MODE_REPEATER  = 3'h5;
  localparam logic [2:0]  MODE_PWRDOWN   = 3'h6;
  localparam logic [2:0]  MODE_ALLCAP    = 3'h7;

  // Decoded defaults of one mode code
  typedef struct packed {
    logic [3:0] ctrlBits;   // Control bits 13,12,10,8
    logic       advValid;   // Advertisement bits are defined
    logic [3:0] advBits;    // Advertisement bits 8,7,6,5
    logic       powerDown;  // Come up powered down
    logic       crsOnTx;    // Carrier sense also during transmit
    logic       repeater;   // Repeater operation
  } pscl_mode_cfg_s;

  // Loader states
  typedef enum logic [2:0] {
    ST_HWRST = 3'b001,
    ST_RUN   = 3'b010,
    ST_SRST  = 3'b100
  } pscl_state_e;

endpackage

// file: pscl_strap_model.sv
// Board strap source for the strap configuration loader
module pscl_strap_model (
  input  wire logic       mclk,
  input  wire logic [4:0] addrSet,
  input  wire logic [2:0] modeSet,
  output logic      [4:0] station_address_straps,
  output logic      [2:0] modeStraps
);
  timeunit 1ns;
  timeprecision 1ps;
  // Straps move only on request, otherwise held steady
  always_ff @(posedge mclk) begin
    station_address_straps <= addrSet;
    modeStraps             <= modeSet;
  end
endmodule // pscl_strap_model

// file: pscl_tb.sv
// Self-checking bench for the strap configuration loader
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 0, arst_n = 0, porReset = 0, pinN = 0, regWrite = 0, regRead = 0;
  logic        frmValid = 0, txAct = 0, rxAct = 0, rdPend = 0;
  logic [4:0]  addrSet = 0, frmAddr = 0, indRaw = 0, straps, seed, indOut;
  logic [2:0]  modeSet = 0, mode;
  logic [7:0]  regAddr = 0;
  logic [15:0] regWdata = 0, rdata, ctrlV, advV;
  logic        match, crs, coreRst, pdn, rep;
  logic [31:0] rs = 48;
  logic [15:0] expQ[$];
  int          n_errors = 0, total_checks = 0, cyc = 0;
  logic [15:0] CT[8] = '{16'h0000, 16'h0100, 16'h2000, 16'h2100, 16'h3000, 16'h3000, 16'h0800, 16'h3100};
  logic [15:0] AD[8] = '{16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0081, 16'h0081, 16'h0001, 16'h01e1};
  logic [7:0]  TXM = 8'h95;
  always #5 mclk = ~mclk;
  pscl_strap_model model (.mclk(mclk), .addrSet(addrSet), .modeSet(modeSet), .station_address_straps(straps),
    .modeStraps(mode));
  pscl_loader #(.SoftRstCycles(8)) dut (.mclk(mclk), .arst_n(arst_n), .porReset(porReset),
    .hardware_reset_pin_n(pinN), .station_address_straps(straps), .modeStraps(mode), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(rdata), .mgmtFrameValid(frmValid),
    .mgmtFrameAddr(frmAddr), .mgmtAddrMatch(match), .scramblerSeed(seed), .txActive(txAct), .rxActive(rxAct),
    .carrierSense(crs), .indicatorRaw(indRaw), .indicatorOut(indOut), .coreReset(coreRst), .powerDown(pdn),
    .repeaterMode(rep), .ctrlValue(ctrlV), .advValue(advV));
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] e);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    expQ.push_back(e);
    @(posedge mclk);
    regRead <= 1'b0;
  endtask
  // Hardware reset by pin or power-on source, then release
  task automatic cap(logic [2:0] c, logic [4:0] a, logic por);
    @(posedge mclk);
    modeSet <= c;
    addrSet <= a;
    porReset <= por;
    pinN <= por;
    repeat (3) @(posedge mclk);
    porReset <= 1'b0;
    pinN <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
  // One strap code: decode, frame match, carrier, indicators, registers
  task automatic runCode(int c);
    logic [4:0] a;
    logic [4:0] r;
    a = 5'(xs());
    r = 5'(xs());
    cap(3'(c), a, c[0]);
    @(negedge mclk);
    chk("ctrl", ctrlV, CT[c]);
    chk("adv", advV, AD[c]);
    chk("seed", 16'(seed), 16'(a));
    chk("pdn", 16'(pdn), 16'(c == 6));
    chk("rep", 16'(rep), 16'(c == 5));
    @(posedge mclk);
    txAct <= 1'b1;
    frmValid <= 1'b1;
    frmAddr <= a;
    indRaw <= r;
    @(posedge mclk);
    frmAddr <= a ^ 5'h01;
    @(negedge mclk);
    chk("crs", 16'(crs), 16'(TXM[c]));
    chk("match", 16'(match), 16'h0001);
    chk("led", 16'(indOut), 16'(r ^ a));
    @(negedge mclk);
    chk("miss", 16'(match), 16'h0000);
    @(posedge mclk);
    txAct <= 1'b0;
    rxAct <= 1'b1;
    rd(pscl_pkg::REG_STAT_OFS, {5'h00, c == 5, TXM[c], 1'b0, 3'(c), a});
    rd(pscl_pkg::REG_CTRL_OFS, CT[c]);
    rd(8'h0c, 16'h0000);
    rxAct <= 1'b0;
    frmValid <= 1'b0;
  endtask
  // Read data compared with the oldest note one cycle after the strobe
  always @(posedge mclk) rdPend <= regRead;
  always @(negedge mclk) begin
    if (rdPend === 1'b1) chk("rdata", rdata, expQ.size() > 0 ? expQ.pop_front() : 16'hdead);
  end
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    for (int c = 0; c < 8; c++) runCode(c);
    cap(3'h6, 5'h0a, 1'b0);
    @(posedge mclk);
    modeSet <= 3'h3;
    wr(pscl_pkg::REG_CTRL_OFS, 16'h8800);
    @(negedge mclk);
    chk("busy", 16'(coreRst), 16'h0001);
    repeat (10) @(negedge mclk);
    chk("idle", 16'(coreRst), 16'h0000);
    chk("wake", ctrlV, 16'h2100);
    chk("pdn", 16'(pdn), 16'h0000);
    @(posedge mclk);
    modeSet <= 3'h4;
    wr(pscl_pkg::REG_CTRL_OFS, 16'ha100);
    repeat (12) @(negedge mclk);
    chk("keep", ctrlV, 16'h2100);
    chk("keepadv", advV, 16'h0001);
    results();
  end
endmodule // testbench
